// ==== src/fifo_device_end.sv ====
// Device end: four endpoint FIFOs behind the asynchronous slave port
// Operation
// RULE1 - Flags and data follow endpoint select
// RULE2 - Output enable alone drives previous word (the code drives it only with output enable and slave select both active)
// RULE3 - Read valid only with select and strobe
// RULE4 - Read strobe drives word, then advances pointer
// RULE5 - Master holds output enable during reads
// RULE6 - Master sets select, then slave select (the master drives both on the same clock edge)
// RULE7 - Master holds data until write release
// RULE8 - Write release stores word, post-increments
// RULE9 - Flags update after each write release
// RULE10 - Commit strobe hands short packet over
// RULE11 - Commit never overlaps the write strobe
// RULE12 - Select held steady during commit
// RULE13 - Endpoint two empty until host data
// RULE14 - Other reads never empty endpoint two
// RULE15 - Workaround: dummy write pulse elsewhere
// RULE16 - Workaround: longer first packet, priority
// RULE17 - Strobes synchronised, edges detected safely
`timescale 1ns/1ps
`include "fifo_port_regs.svh"
module fifo_device_end
  import fifo_port_pkg::*;
(
  input  wire logic   clk_sys,          // System clock, 25 MHz
  input  wire logic   rst,              // Synchronous reset, active high
  fifo_port_if.device port,             // Pins toward the master
  input  wire logic   host_valid,       // Host delivers a word into endpoint two
  input  wire word_t  host_data,        // Host word for endpoint two
  output logic        commit_pulse,     // Short packet handed to host
  output sel_t        commit_ep,        // Endpoint of that packet
  output logic [`PTR_W:0] commit_count  // Words in that packet
);
  // Three-stage synchronisers for strobes, select and data
  localparam int SW = 5 + `SEL_W + `DATA_W;
  logic [SW-1:0] s1_r, s2_r, s3_r;      // Stage flops
  logic [SW-1:0] s1_nxt;                // Raw pin sample
  logic          rd_act, wr_act, pe_act, cs_act; // Agreed levels
  logic          oe_act;                // Agreed output enable level
  logic          rd_q_r, wr_q_r, pe_q_r;          // Previous agreed levels
  sel_t          sel_s;                 // Synchronised select
  word_t         din_s;                 // Synchronised data

  always_comb begin
    s1_nxt = {~port.fifo_output_enable_n, ~port.slave_select_n, ~port.fifo_read_strobe_n,
              ~port.fifo_write_strobe_n, ~port.packet_commit_strobe_n,
              port.endpoint_select, port.data_bus};
  end

  // Only stages two and three are looked at; stage one feeds stage two alone
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A level counts only once stages two and three agree
  logic [SW-1:0] agree_nxt, agree_r;
  always_comb begin
    agree_nxt = agree_r;
    for (int i = 0; i < SW; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        agree_nxt[i] = s3_r[i]; // RULE17
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) agree_r <= '0;
    else     agree_r <= agree_nxt;
  end
  assign oe_act = agree_r[SW-1];
  assign cs_act = agree_r[SW-2];
  assign rd_act = agree_r[SW-3];
  assign wr_act = agree_r[SW-4];
  assign pe_act = agree_r[SW-5];
  assign sel_s  = agree_r[`DATA_W +: `SEL_W];
  assign din_s  = agree_r[`DATA_W-1:0];

  // Edge detectors on the agreed strobe levels
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_q_r <= 1'b0;
      wr_q_r <= 1'b0;
      pe_q_r <= 1'b0;
    end else begin
      rd_q_r <= rd_act;
      wr_q_r <= wr_act;
      pe_q_r <= pe_act;
    end
  end
  // Slave select is active low; the master drives it low from setup through release
  // of every transfer and high when idle, so qualifying with it is safe
  logic rd_rise, wr_fall, pe_rise;
  assign rd_rise = rd_act & ~rd_q_r & cs_act;        // RULE3
  assign wr_fall = ~wr_act & wr_q_r;
  assign pe_rise = pe_act & ~pe_q_r;

  // Endpoint storage; the array is small enough for registers
  word_t              mem_r [`EP_COUNT][`FIFO_DEPTH];
  logic [`PTR_W:0]    wp_r [`EP_COUNT], rp_r [`EP_COUNT], cp_r [`EP_COUNT];
  logic [`PTR_W:0]    wp_nxt [`EP_COUNT], rp_nxt [`EP_COUNT], cp_nxt [`EP_COUNT];
  logic               fetch_nxt;
  word_t              held_r, held_nxt;   // Last word fetched for the bus
  logic               commit_nxt;
  logic [`PTR_W:0]    count_nxt;

  // Pointer bookkeeping for all endpoints
  always_comb begin
    fetch_nxt  = 1'b0;
    held_nxt   = held_r;
    commit_nxt = 1'b0;
    count_nxt  = commit_count;
    for (int e = 0; e < `EP_COUNT; e++) begin
      wp_nxt[e] = wp_r[e];
      rp_nxt[e] = rp_r[e];
      cp_nxt[e] = cp_r[e];
    end
    // Host arrivals land in endpoint two only
    if (host_valid && (wp_r[0] - rp_r[0]) != (`PTR_W+1)'(`FIFO_DEPTH)) begin
      wp_nxt[0] = wp_r[0] + 1'b1;        // RULE13
    end
    // Read: present the head word, then advance that endpoint only
    if (rd_rise && rp_r[sel_s] != wp_r[sel_s]) begin
      held_nxt      = mem_r[sel_s][rp_r[sel_s][`PTR_W-1:0]]; // RULE4
      rp_nxt[sel_s] = rp_r[sel_s] + 1'b1; // RULE14
    end
    // Write on release edge, post-increment afterwards
    if (wr_fall && sel_s != `EP_OUT_TWO &&
        (wp_r[sel_s] - rp_r[sel_s]) != (`PTR_W+1)'(`FIFO_DEPTH)) begin
      fetch_nxt     = 1'b1;
      wp_nxt[sel_s] = wp_r[sel_s] + 1'b1; // RULE8
    end
    // Commit hands uncommitted words to the host side
    if (pe_rise && sel_s != `EP_OUT_TWO) begin
      commit_nxt    = 1'b1;               // RULE10
      count_nxt     = wp_r[sel_s] - cp_r[sel_s];
      cp_nxt[sel_s] = wp_r[sel_s];
      rp_nxt[sel_s] = wp_r[sel_s];       // Host side drains the packet
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int e = 0; e < `EP_COUNT; e++) begin
        wp_r[e] <= '0;
        rp_r[e] <= '0;
        cp_r[e] <= '0;
      end
      held_r       <= '0;
      commit_pulse <= 1'b0;
      commit_count <= '0;
      commit_ep    <= '0;
    end else begin
      for (int e = 0; e < `EP_COUNT; e++) begin
        wp_r[e] <= wp_nxt[e];
        rp_r[e] <= rp_nxt[e];
        cp_r[e] <= cp_nxt[e];
      end
      held_r       <= held_nxt;
      commit_pulse <= commit_nxt;
      commit_count <= count_nxt;
      if (commit_nxt) commit_ep <= sel_s;
    end
  end

  // Storage write: host data into endpoint two, bus data elsewhere
  // A host word is stored only when it was counted, so a full FIFO keeps its head
  always_ff @(posedge clk_sys) begin
    if (wp_nxt[0] != wp_r[0]) begin
      mem_r[0][wp_r[0][`PTR_W-1:0]] <= host_data;
    end
    if (fetch_nxt) begin
      mem_r[sel_s][wp_r[sel_s][`PTR_W-1:0]] <= din_s; // RULE8
    end
  end

  // Per-endpoint flags; the output stage picks the synchronised select
  logic [`EP_COUNT-1:0] empty_vec, full_vec;
  for (genvar g = 0; g < `EP_COUNT; g++) begin : g_flag
    assign empty_vec[g] = (wp_r[g] == rp_r[g]);   // RULE9
    assign full_vec[g]  = ((wp_r[g] - rp_r[g]) == (`PTR_W+1)'(`FIFO_DEPTH));
  end

  // Output flops; a select change shows a few clocks late, the price of a safe
  // synchroniser on pins that move with no relation to our clock
  logic  eflag_nxt, fflag_nxt, oe_nxt;
  always_comb begin
    eflag_nxt = ~empty_vec[sel_s];   // RULE1
    fflag_nxt = ~full_vec[sel_s];
    oe_nxt    = ~(oe_act & cs_act);  // RULE2
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port.empty_n          <= 1'b0;  // RULE13
      port.full_n           <= 1'b1;
      port.device_oe_n      <= 1'b1;
      port.data_from_device <= '0;
    end else begin
      port.empty_n          <= eflag_nxt;
      port.full_n           <= fflag_nxt;
      port.device_oe_n      <= oe_nxt;
      port.data_from_device <= held_r;  // RULE2
    end
  end
endmodule : fifo_device_end

// ==== src/fifo_port_regs.svh ====
// Constants shared by both ends of the asynchronous slave FIFO port
`ifndef FIFO_PORT_REGS_SVH
`define FIFO_PORT_REGS_SVH
`define DATA_W          16
`define SEL_W           2
`define EP_COUNT        4
`define FIFO_DEPTH      16
`define PTR_W           4
`define EP_OUT_TWO      2'h0
`define CLK_NS          40
`define STROBE_LOW_NS   50
`define STROBE_HIGH_NS  50
`define SETUP_NS        10
`define STROBE_LOW_CYC  (((`STROBE_LOW_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define STROBE_HIGH_CYC (((`STROBE_HIGH_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`define SETUP_CYC       (((`SETUP_NS) + (`CLK_NS) - 1) / (`CLK_NS))
`endif

// ==== src/fifo_port_pkg.sv ====
// Types shared by both ends of the asynchronous slave FIFO port
`include "fifo_port_regs.svh"
package fifo_port_pkg;
  typedef logic [`DATA_W-1:0] word_t;   // One bus word
  typedef logic [`SEL_W-1:0]  sel_t;    // Endpoint select value
  typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE, OP_COMMIT} op_t;
endpackage : fifo_port_pkg

// ==== src/fifo_port_if.sv ====
// Pin-level interface between the external master and the FIFO device
`timescale 1ns/1ps
interface fifo_port_if;
  import fifo_port_pkg::*;
  logic  slave_select_n;            // Active-low slave select
  logic  fifo_output_enable_n;      // Active-low output enable
  logic  fifo_read_strobe_n;        // Active-low read strobe
  logic  fifo_write_strobe_n;       // Active-low write strobe
  logic  packet_commit_strobe_n;    // Active-low packet commit
  sel_t  endpoint_select;           // Endpoint select lines
  word_t data_from_master;          // Data driven by the master
  logic  master_oe_n;               // Master drives bus when low
  word_t data_from_device;          // Data driven by the device
  logic  device_oe_n;               // Device drives bus when low
  logic  empty_n;                   // Selected endpoint not empty
  logic  full_n;                    // Selected endpoint not full
  word_t data_bus;                  // Resolved bus level
  assign data_bus = !device_oe_n ? data_from_device :
                    !master_oe_n ? data_from_master : '0;
  modport device (input slave_select_n, fifo_output_enable_n, fifo_read_strobe_n,
                  fifo_write_strobe_n, packet_commit_strobe_n, endpoint_select,
                  data_bus, output data_from_device, device_oe_n, empty_n, full_n);
  modport master (output slave_select_n, fifo_output_enable_n, fifo_read_strobe_n,
                  fifo_write_strobe_n, packet_commit_strobe_n, endpoint_select,
                  data_from_master, master_oe_n, input data_bus, empty_n, full_n);
endinterface : fifo_port_if

// ==== src/fifo_master_end.sv ====
// Master end: sequences reads, writes and commits on the slave port
`timescale 1ns/1ps
`include "fifo_port_regs.svh"
module fifo_master_end
  import fifo_port_pkg::*;
(
  input  wire logic  clk_sys,        // System clock, 25 MHz
  input  wire logic  rst,            // Synchronous reset, active high
  fifo_port_if.master port,          // Pins toward the device
  input  wire logic  req_valid,      // Request strobe, one cycle
  input  wire op_t   req_op,         // Read, write or commit
  input  wire sel_t  req_sel,        // Target endpoint
  input  wire word_t req_data,       // Write data
  output logic       req_ready,      // Idle and able to take a request
  output logic       rsp_valid,      // Read data valid, one cycle
  output word_t      rsp_data,       // Read data
  output logic       empty_n_out,    // Synchronised selected-empty flag
  output logic       init_done       // Dummy write issued after reset
);
  // Generous wait so the device's three-flop synchroniser sees each phase
  localparam int PH = `STROBE_LOW_CYC + 4;
  typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_SETUP, ST_ACT, ST_REL} state_t;
  state_t      st_r, st_nxt;
  op_t         op_r, op_nxt;
  sel_t        sel_r, sel_nxt;
  word_t       wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        boot_r, boot_nxt, rv_nxt;
  logic [2:0]  ef_r;                 // Flag synchroniser
  logic        ef_agree_r;           // Agreed flag level

  // Sequencer: setup, strobe low, strobe high recovery
  always_comb begin
    st_nxt = st_r; op_nxt = op_r; sel_nxt = sel_r; wd_nxt = wd_r;
    rd_nxt = rd_r; cnt_nxt = cnt_r; boot_nxt = boot_r; rv_nxt = 1'b0;
    case (st_r)
      ST_BOOT: begin
        op_nxt = OP_WRITE; sel_nxt = 2'h1;  // RULE15
        st_nxt = ST_SETUP; cnt_nxt = '0;
      end
      ST_IDLE: begin
        if (req_valid) begin
          op_nxt = req_op; sel_nxt = req_sel; wd_nxt = req_data;
          st_nxt = ST_SETUP; cnt_nxt = '0;
        end
      end
      ST_SETUP: begin                          // RULE6
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == 4'(PH)) begin st_nxt = ST_ACT; cnt_nxt = '0; end
      end
      ST_ACT: begin
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == 4'(PH)) begin
          if (op_r == OP_READ) begin rd_nxt = port.data_bus; rv_nxt = 1'b1; end
          st_nxt = ST_REL; cnt_nxt = '0;
        end
      end
      ST_REL: begin                            // RULE11
        cnt_nxt = cnt_r + 1'b1;
        if (cnt_r == 4'(PH)) begin st_nxt = ST_IDLE; boot_nxt = 1'b1; end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= ST_BOOT; op_r <= OP_NONE; sel_r <= '0; wd_r <= '0; rd_r <= '0;
      cnt_r <= '0; boot_r <= 1'b0; rsp_valid <= 1'b0; ef_r <= '0; ef_agree_r <= 1'b0;
    end else begin
      st_r <= st_nxt; op_r <= op_nxt; sel_r <= sel_nxt; wd_r <= wd_nxt;
      rd_r <= rd_nxt; cnt_r <= cnt_nxt; boot_r <= boot_nxt; rsp_valid <= rv_nxt;
      ef_r <= {ef_r[1:0], port.empty_n};
      if (ef_r[1] == ef_r[2]) ef_agree_r <= ef_r[2];
    end
  end

  // Pins are registered so they never glitch
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      port.slave_select_n <= 1'b1; port.fifo_output_enable_n <= 1'b1;
      port.fifo_read_strobe_n <= 1'b1; port.fifo_write_strobe_n <= 1'b1;
      port.packet_commit_strobe_n <= 1'b1; port.endpoint_select <= '0;
      port.data_from_master <= '0; port.master_oe_n <= 1'b1;
      req_ready <= 1'b0; rsp_data <= '0; empty_n_out <= 1'b0; init_done <= 1'b0;
    end else begin
      port.endpoint_select  <= sel_nxt;     // RULE12
      port.slave_select_n   <= (st_nxt == ST_IDLE) || (st_nxt == ST_BOOT); // RULE3
      port.fifo_output_enable_n <= !((st_nxt == ST_ACT) && (op_nxt == OP_READ)); // RULE5
      port.fifo_read_strobe_n   <= !((st_nxt == ST_ACT) && (op_nxt == OP_READ));
      port.fifo_write_strobe_n  <= !((st_nxt == ST_ACT) && (op_nxt == OP_WRITE));
      port.packet_commit_strobe_n <= !((st_nxt == ST_ACT) && (op_nxt == OP_COMMIT));
      port.data_from_master <= wd_nxt;      // RULE7
      port.master_oe_n      <= !(op_nxt == OP_WRITE && st_nxt != ST_IDLE);
      req_ready   <= (st_nxt == ST_IDLE);
      rsp_data    <= rd_nxt;
      empty_n_out <= ef_agree_r;
      init_done   <= boot_nxt;              // RULE15
    end
  end
endmodule : fifo_master_end

// ==== dv/fifo_port_asserts.sv ====
// Checker for the pin-level rules of the slave FIFO port
`timescale 1ns/1ps
`include "fifo_port_regs.svh"
module fifo_port_asserts
  import fifo_port_pkg::*;
(
  input wire logic  clk_sys,                // System clock
  input wire logic  rst,                    // Synchronous reset
  input wire logic  slave_select_n,         // Slave select
  input wire logic  fifo_output_enable_n,   // Output enable
  input wire logic  fifo_read_strobe_n,     // Read strobe
  input wire logic  fifo_write_strobe_n,    // Write strobe
  input wire logic  packet_commit_strobe_n, // Commit strobe
  input wire sel_t  endpoint_select,        // Endpoint select
  input wire word_t data_from_master,       // Master data
  input wire logic  master_oe_n,            // Master drive enable
  input wire word_t data_from_device,       // Device data
  input wire logic  device_oe_n,            // Device drive enable
  input wire logic  empty_n,                // Selected not empty
  input wire logic  full_n                  // Selected not full
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Commit must keep clear of the write strobe, with its inactive width behind it
  chk_commit_apart: assert property (
    !packet_commit_strobe_n |-> fifo_write_strobe_n && $past(fifo_write_strobe_n, 2))
    else $error("Commit strobe overlaps or follows the write strobe too soon");
  chk_select_commit: assert property (
    !packet_commit_strobe_n |-> $stable(endpoint_select))
    else $error("Endpoint select moved during commit");
  chk_read_select: assert property (
    $fell(fifo_read_strobe_n) |-> !$past(slave_select_n))
    else $error("Read strobe fell without slave select set up first");
  chk_read_oe: assert property (
    !fifo_read_strobe_n |-> !fifo_output_enable_n)
    else $error("Read strobe active without output enable");
  // Select must already be settled, and held through a strobe of two cycles
  chk_write_setup: assert property (
    $fell(fifo_write_strobe_n) |-> $stable(endpoint_select)
      ##1 (!fifo_write_strobe_n && $stable(endpoint_select)))
    else $error("Write strobe without settled select or too short");
  chk_write_data: assert property (
    $rose(fifo_write_strobe_n) |-> !$past(master_oe_n) && $stable(data_from_master))
    else $error("Write data not driven and steady at strobe release");
  // Sync delay plus flag register stays well inside this window
  chk_write_flags: assert property (
    $rose(fifo_write_strobe_n) && endpoint_select != `EP_OUT_TWO && full_n
      |-> ##[1:8] empty_n)
    else $error("Empty flag not cleared after an accepted write");
  chk_oe_drives: assert property (
    $fell(fifo_output_enable_n) |-> ##[0:6] !device_oe_n)
    else $error("Device did not drive the bus under output enable");
  // Between reads the bus word is the one fetched before; it moves only on a read
  chk_held_word: assert property (
    $changed(data_from_device) |-> !fifo_read_strobe_n || !$past(fifo_read_strobe_n))
    else $error("Device bus word changed without a read strobe");
  // Seen at the release edge, so the reset itself must not mask it
  chk_empty_reset: assert property (
    @(posedge clk_sys) disable iff (1'b0) $fell(rst) |-> !empty_n)
    else $error("Selected endpoint not empty after reset");

  cov_read: cover property ($fell(fifo_read_strobe_n));
  cov_write: cover property ($fell(fifo_write_strobe_n));
  cov_commit: cover property ($fell(packet_commit_strobe_n));
endmodule : fifo_port_asserts

// ==== dv/test_async_slave_fifo_port.sv ====
// Testbench joining the master and device ends of the slave FIFO port
`timescale 1ns/1ps
`include "fifo_port_regs.svh"
`define CHK(what, exp, got) begin compares++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module test_async_slave_fifo_port
  import fifo_port_pkg::*;
;
  logic            clk_sys;      // Bench clock
  logic            rst;          // Synchronous reset
  logic            req_valid;    // Request strobe
  op_t             req_op;       // Request kind
  sel_t            req_sel;      // Request endpoint
  word_t           req_data;     // Write word
  logic            req_ready;    // Master idle
  logic            rsp_valid;    // Read word valid
  word_t           rsp_data;     // Read word
  logic            empty_n_out;  // Master's synced selected-empty flag
  logic            init_done;    // Dummy write done
  logic            host_valid;   // Host word strobe
  word_t           host_data;    // Host word
  logic            commit_pulse; // Packet handed over
  sel_t            commit_ep;    // Its endpoint
  logic [`PTR_W:0] commit_count; // Its length
  sel_t            cm_ep;        // Last packet endpoint
  logic [`PTR_W:0] cm_cnt;       // Last packet length
  int              err_count;    // Mismatches
  int              compares;     // Comparisons made

  fifo_port_if pins ();
  fifo_device_end fifo_device_end_inst (.clk_sys(clk_sys), .rst(rst), .port(pins.device),
    .host_valid(host_valid), .host_data(host_data), .commit_pulse(commit_pulse),
    .commit_ep(commit_ep), .commit_count(commit_count));
  fifo_master_end fifo_master_end_inst (.clk_sys(clk_sys), .rst(rst), .port(pins.master),
    .req_valid(req_valid), .req_op(req_op), .req_sel(req_sel), .req_data(req_data),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .empty_n_out(empty_n_out), .init_done(init_done));
  fifo_port_asserts fifo_port_asserts_inst (.clk_sys(clk_sys), .rst(rst),
    .slave_select_n(pins.slave_select_n), .fifo_output_enable_n(pins.fifo_output_enable_n),
    .fifo_read_strobe_n(pins.fifo_read_strobe_n),
    .fifo_write_strobe_n(pins.fifo_write_strobe_n),
    .packet_commit_strobe_n(pins.packet_commit_strobe_n),
    .endpoint_select(pins.endpoint_select), .data_from_master(pins.data_from_master),
    .master_oe_n(pins.master_oe_n), .data_from_device(pins.data_from_device),
    .device_oe_n(pins.device_oe_n), .empty_n(pins.empty_n), .full_n(pins.full_n));

  // 25 MHz system clock
  always #20 clk_sys = ~clk_sys;

  // The commit pulse lasts one cycle, so keep what it carried
  always @(posedge clk_sys) begin
    if (commit_pulse === 1'b1) begin
      cm_ep  <= commit_ep;
      cm_cnt <= commit_count;
    end
  end

  // Single place where the run ends
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  task automatic timeout(input string what);
    err_count++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    results();
  endtask : timeout

  // Sampled on the falling edge, where registered outputs have settled
  task automatic wait_ready();
    int i;
    @(negedge clk_sys);
    for (i = 0; i < 200 && req_ready !== 1'b1; i++) begin
      @(negedge clk_sys);
    end
    if (req_ready !== 1'b1) timeout("req_ready");
  endtask : wait_ready

  // One request through the master; a read is compared against exp
  task automatic xfer(input op_t op, input sel_t sel, input word_t d, input word_t exp);
    int i;
    wait_ready();
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_op    <= op;
    req_sel   <= sel;
    req_data  <= d;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    if (op == OP_READ) begin
      for (i = 0; i < 100 && rsp_valid !== 1'b1; i++) begin
        @(negedge clk_sys);
      end
      if (rsp_valid !== 1'b1) timeout("rsp_valid");
      `CHK("rsp_data", exp, rsp_data)
    end
    wait_ready();
  endtask : xfer

  // Flags of whatever endpoint the pins select now; the wait lets the master's
  // own flag synchroniser catch up before both copies are compared
  task automatic flags(input logic e, input logic f);
    repeat (6) @(negedge clk_sys);
    `CHK("empty_n", e, pins.empty_n)
    `CHK("empty_n_out", e, empty_n_out)
    `CHK("full_n", f, pins.full_n)
  endtask : flags

  initial begin
    int k;
    clk_sys = 1'b0;
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = OP_NONE;
    req_sel = '0;
    req_data = '0;
    host_valid = 1'b0;
    host_data = '0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    wait_ready();
    `CHK("init_done", 1'b1, init_done)
    // The init pulse left one word in endpoint 1; hand it over as a short packet
    xfer(OP_COMMIT, 2'h1, 16'h0000, 16'h0000);
    `CHK("commit_ep", 2'h1, cm_ep)
    `CHK("commit_count", 5'h01, cm_cnt)
    flags(1'b0, 1'b1);
    // Writes to endpoint two are ignored, so it stays empty
    xfer(OP_WRITE, `EP_OUT_TWO, 16'hDEAD, 16'h0000);
    flags(1'b0, 1'b1);
    @(posedge clk_sys);
    host_valid <= 1'b1;
    host_data  <= 16'hA5A5;
    @(posedge clk_sys);
    host_valid <= 1'b0;
    for (k = 0; k < 50 && pins.empty_n !== 1'b1; k++) begin
      @(negedge clk_sys);
    end
    flags(1'b1, 1'b1);
    // A read elsewhere after a one-word first packet must not hide that word
    xfer(OP_WRITE, 2'h3, 16'h3C3C, 16'h0000);
    xfer(OP_READ, 2'h3, 16'h0000, 16'h3C3C);
    flags(1'b0, 1'b1);
    xfer(OP_READ, `EP_OUT_TWO, 16'h0000, 16'hA5A5);
    flags(1'b0, 1'b1);
    // Three words then a commit: the packet length must count them all
    for (k = 0; k < 3; k++) begin
      xfer(OP_WRITE, 2'h2, word_t'(16'h2000 + k), 16'h0000);
    end
    flags(1'b1, 1'b1);
    xfer(OP_COMMIT, 2'h2, 16'h0000, 16'h0000);
    `CHK("commit_ep", 2'h2, cm_ep)
    `CHK("commit_count", 5'h03, cm_cnt)
    flags(1'b0, 1'b1);
    // Fill endpoint 1 past full; the extra word must be refused, then drain in order
    for (k = 0; k < `FIFO_DEPTH + 1; k++) begin
      xfer(OP_WRITE, 2'h1, word_t'(16'h1000 + k), 16'h0000);
    end
    flags(1'b1, 1'b0);
    for (k = 0; k < `FIFO_DEPTH; k++) begin
      xfer(OP_READ, 2'h1, 16'h0000, word_t'(16'h1000 + k));
    end
    flags(1'b0, 1'b1);
    // Two host words; endpoint two returns them in arrival order
    @(posedge clk_sys);
    host_valid <= 1'b1;
    host_data  <= 16'h5A01;
    @(posedge clk_sys);
    host_data  <= 16'h5A02;
    @(posedge clk_sys);
    host_valid <= 1'b0;
    xfer(OP_READ, `EP_OUT_TWO, 16'h0000, 16'h5A01);
    xfer(OP_READ, `EP_OUT_TWO, 16'h0000, 16'h5A02);
    flags(1'b0, 1'b1);
    results();
  end
endmodule : test_async_slave_fifo_port
